//--- logic/led_strap_pkg.sv
package led_strap_pkg;

  // ----------------------------------------
  // strap values latched at reset release
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] swap;
    logic gang;
    logic [1:0] boost;
  } strap_type;

  // which straps the package and configuration allow
  typedef struct packed {
    logic swap;
    logic gang;
    logic boost;
  } strap_en_type;

  // sampling phase
  typedef enum logic [0:0] {
    phase_hold,
    phase_run
  } phase_type;

endpackage : led_strap_pkg

//--- logic/led_strap_regs.svh
`ifndef LED_STRAP_REGS_SVH
`define LED_STRAP_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CTRL_OFS 8'h00
`define BOOST_OFS 8'h04
`define STATUS_OFS 8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_LED_EN_BIT 0
`define STATUS_SWAP_LSB 0
`define STATUS_GANG_BIT 4
`define STATUS_BOOST_LSB 5
`define STATUS_VALID_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RESET 1'h0
`define BOOST_RESET 2'h0
`define SWAP_RESET 4'h0
`define GANG_RESET 1'h0

`endif

//--- logic/led_strap_sampler.sv
// Functional notes
// - one primary LED per downstream port 1-4, active low when LED support is enabled and its swap strap is off or 1.
// - with the swap strap enabled, each primary LED pin is sampled at reset release to set data-pair polarity.
// - swap strap 0 keeps normal polarity and an active-high LED, 1 swaps the pair and gives an active-low LED.
// - an enhanced LED for port 4 is driven active low when LED support is enabled.
// - the port 3 enhanced LED shares the gang strap pin and is active low when LED support is enabled and the gang strap is off or 1.
// - with the gang strap enabled, the port 3 enhanced LED pin is sampled at reset release to pick ganged power.
// - gang strap 0 gives individual switching and an active-high LED, 1 gives ganged and an active-low LED.
// - the port 1 and 2 enhanced LEDs share the boost strap pins and are active low when LED support is enabled and the boost strap is off or its bit is 1.
// - with the boost strap enabled, both port 1/2 enhanced LED pins are sampled at reset release.
// - the sampled boost strap loads the two-bit PHY output current setting directly.
// - boost 11 makes both port 1 and port 2 enhanced LEDs active low.
`include "led_strap_regs.svh"

module led_strap_sampler (
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // strap enables from package and configuration
  input wire led_strap_pkg::strap_en_type strap_en,
  // lamp requests, high means lit
  input wire logic [3:0] primary_led_req,
  input wire logic [3:0] enhanced_led_req,
  // shared LED / strap pins
  input wire logic [3:0] primary_led_in,
  output logic [3:0] port_primary_led_out,
  output logic [3:0] primary_led_oe,
  input wire logic port4_enhanced_led_in,
  output logic port4_enhanced_led_out,
  output logic port4_enhanced_led_oe,
  input wire logic port3_enhanced_led_in,
  output logic port3_enhanced_led_out,
  output logic port3_enhanced_led_oe,
  input wire logic [1:0] port12_enhanced_led_in,
  output logic [1:0] port12_enhanced_led_out,
  output logic [1:0] port12_enhanced_led_oe,
  // latched configuration
  output logic [3:0] port_pair_swap_strap,
  output logic gang_power_mode,
  output logic [1:0] phy_output_current_setting
);

  // ----------------------------------------
  // sampling phase
  // ----------------------------------------
  led_strap_pkg::phase_type phase;
  led_strap_pkg::strap_type strap;
  logic strap_valid;
  logic led_support_en;
  logic capture;

  // capture happens on the first edge with reset released, never under reset itself
  assign capture = (phase == led_strap_pkg::phase_hold);

  // hold phase during reset, run afterwards
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase <= led_strap_pkg::phase_hold;
    end else begin
      phase <= led_strap_pkg::phase_run;
    end
  end

  // ----------------------------------------
  // strap latch
  // ----------------------------------------
  // disabled straps fall back to their neutral value
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      strap.swap <= `SWAP_RESET;
      strap.gang <= `GANG_RESET;
      strap.boost <= `BOOST_RESET;
      strap_valid <= 1'h0;
    end else if (capture) begin
      strap.swap <= strap_en.swap ? primary_led_in : `SWAP_RESET;
      strap.gang <= strap_en.gang ? port3_enhanced_led_in : `GANG_RESET;
      strap.boost <= strap_en.boost ? port12_enhanced_led_in : `BOOST_RESET;
      strap_valid <= 1'h1;
    end
  end

  // swap and gang straight from the latch
  assign port_pair_swap_strap = strap.swap;
  assign gang_power_mode = strap.gang;

  // ----------------------------------------
  // polarity of each LED
  // ----------------------------------------
  // bit set means active low; without a strap the pin keeps the plain active-low sense
  // a strap only acts where enabled, so a board without pulls still gets plain LEDs
  logic [3:0] primary_pol_low;
  logic [3:0] enhanced_pol_low;

  always_comb begin
    primary_pol_low = strap_en.swap ? strap.swap : 4'hf;
    enhanced_pol_low[3] = 1'h1;
    enhanced_pol_low[2] = strap_en.gang ? strap.gang : 1'h1;
    enhanced_pol_low[1:0] = strap_en.boost ? strap.boost : 2'h3;
  end

  // ----------------------------------------
  // LED drivers
  // ----------------------------------------
  logic [7:0] led_out;
  logic [7:0] led_oe;
  logic [7:0] led_req;
  logic [7:0] led_pol;

  assign led_req = {enhanced_led_req, primary_led_req};
  assign led_pol = {enhanced_pol_low, primary_pol_low};

  // pins stay released in reset and in the capture cycle so the straps are readable
  generate
    for (genvar i = 0; i < 8; i++) begin : g_led
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          led_out[i] <= 1'h0;
          led_oe[i] <= 1'h0;
        end else begin
          led_out[i] <= led_req[i] ^ led_pol[i];
          led_oe[i] <= led_support_en && !capture;
        end
      end
    end
  endgenerate

  // bit order: primary 3:0, then enhanced port 1, port 2, port 3, port 4
  assign port_primary_led_out = led_out[3:0];
  assign primary_led_oe = led_oe[3:0];
  assign port12_enhanced_led_out = led_out[5:4];
  assign port12_enhanced_led_oe = led_oe[5:4];
  assign port3_enhanced_led_out = led_out[6];
  assign port3_enhanced_led_oe = led_oe[6];
  assign port4_enhanced_led_out = led_out[7];
  assign port4_enhanced_led_oe = led_oe[7];

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // one decode per writable register; the status offset has none, so writes there fall away
  logic ctrl_wr;
  logic boost_wr;

  assign ctrl_wr = reg_wr && (reg_addr == `CTRL_OFS);
  assign boost_wr = reg_wr && (reg_addr == `BOOST_OFS);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // LED support is a software switch; until it is set the strap pins stay released
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      led_support_en <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      led_support_en <= reg_wdata[`CTRL_LED_EN_BIT];
    end
  end

  // ----------------------------------------
  // PHY output current setting
  // ----------------------------------------
  // strap loads it once; software may retune it later through the same field
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phy_output_current_setting <= `BOOST_RESET;
    end else if (capture) begin
      phy_output_current_setting <= strap_en.boost ? port12_enhanced_led_in : `BOOST_RESET;
    end else if (boost_wr) begin
      phy_output_current_setting <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // valid only in the cycle after the strobe, zero otherwise and for unmapped offsets
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CTRL_OFS: reg_rdata <= {31'h0, led_support_en};
        `BOOST_OFS: reg_rdata <= {30'h0, phy_output_current_setting};
        `STATUS_OFS: reg_rdata <= {24'h0, strap_valid, strap.boost, strap.gang, strap.swap};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_primary_led_drive: assert property (
    (led_support_en && !capture && !strap_en.swap) |=> (port_primary_led_out == ~$past(primary_led_req))
  ) else $error("primary LED not active low");

  a_swap_sample: assert property (
    capture |=> (port_pair_swap_strap == (strap_en.swap ? $past(primary_led_in) : 4'h0))
  ) else $error("swap strap not sampled at reset release");

  a_swap_led_sense: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.swap && $stable(strap_en))
      |=> (port_primary_led_out == ($past(primary_led_req) ^ $past(port_pair_swap_strap)))
  ) else $error("primary LED sense does not follow swap strap");

  a_port4_low: assert property (
    ##1 1'h1 |-> (port4_enhanced_led_out == ~$past(enhanced_led_req[3]))
  ) else $error("port 4 enhanced LED not active low");

  a_port3_sense: assert property (
    (phase == led_strap_pkg::phase_run && $stable(strap_en))
      |=> (port3_enhanced_led_out == ($past(enhanced_led_req[2]) ^ (!strap_en.gang || gang_power_mode)))
  ) else $error("port 3 enhanced LED sense wrong");

  a_gang_sample: assert property (
    capture |=> (gang_power_mode == (strap_en.gang && $past(port3_enhanced_led_in)))
  ) else $error("gang strap not sampled at reset release");

  a_boost_load: assert property (
    (capture && strap_en.boost) |=> (phy_output_current_setting == $past(port12_enhanced_led_in))
  ) else $error("boost strap not loaded into current setting");

  a_boost_sense: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.boost && $stable(strap_en))
      |=> (port12_enhanced_led_out == ($past(enhanced_led_req[1:0]) ^ $past(strap.boost)))
  ) else $error("port 1/2 enhanced LED sense wrong");

  a_boost_both_low: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.boost && strap.boost == 2'h3 && $stable(strap_en))
      |=> (port12_enhanced_led_out == ~$past(enhanced_led_req[1:0]))
  ) else $error("boost 11 does not give active-low LEDs");

  a_strap_hold: assert property (
    (phase == led_strap_pkg::phase_run) |=> ($stable(strap) && strap_valid)
  ) else $error("latched strap changed after release");

  a_pins_released: assert property (
    capture |=> (led_oe == 8'h0)
  ) else $error("strap pins driven in capture cycle");

  // ----------------------------------------
  // assertions: pin drivers
  // ----------------------------------------
  // the enable follows the software switch one edge later, never in the capture cycle
  a_oe_enabled: assert property (
    (led_support_en && !capture)
      |=> (led_oe == 8'hff)
  ) else $error("LED pins not driven with support enabled");

  // released pins let the pulls show, which is what the next reset samples
  a_oe_disabled: assert property (
    !led_support_en
      |=> (led_oe == 8'h00)
  ) else $error("LED pins driven with support disabled");

  // without its strap an LED keeps the plain active-low sense
  a_port3_plain: assert property (
    !strap_en.gang
      |=> (port3_enhanced_led_out == ~$past(enhanced_led_req[2]))
  ) else $error("port 3 enhanced LED not active low without strap");

  a_port12_plain: assert property (
    !strap_en.boost
      |=> (port12_enhanced_led_out == ~$past(enhanced_led_req[1:0]))
  ) else $error("port 1/2 enhanced LEDs not active low without strap");

  a_gang_led_sense: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.gang)
      |=> (port3_enhanced_led_out == ($past(enhanced_led_req[2]) ^ $past(gang_power_mode)))
  ) else $error("port 3 enhanced LED sense does not follow gang strap");

  a_gang_led_low: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.gang && gang_power_mode)
      |=> (port3_enhanced_led_out == ~$past(enhanced_led_req[2]))
  ) else $error("ganged mode does not give an active-low port 3 LED");

  a_swap_all_low: assert property (
    (phase == led_strap_pkg::phase_run && strap_en.swap && port_pair_swap_strap == 4'hf)
      |=> (port_primary_led_out == ~$past(primary_led_req))
  ) else $error("swapped pairs do not give active-low primary LEDs");

  // ----------------------------------------
  // assertions: register port and latch
  // ----------------------------------------
  // the strap load owns the capture edge, software owns every edge after it
  a_boost_default: assert property (
    (capture && !strap_en.boost)
      |=> (phy_output_current_setting == 2'h0)
  ) else $error("current setting not cleared without boost strap");

  // a write at the capture edge is lost on purpose, the strap wins there
  a_boost_write: assert property (
    (!capture && boost_wr)
      |=> (phy_output_current_setting == $past(reg_wdata[1:0]))
  ) else $error("current setting write lost");

  a_boost_steady: assert property (
    (!capture && !boost_wr)
      |=> $stable(phy_output_current_setting)
  ) else $error("current setting changed without a write");

  a_boost_readback: assert property (
    (reg_rd && reg_addr == `BOOST_OFS)
      |=> (reg_rdata == {30'h0, $past(phy_output_current_setting)})
  ) else $error("current setting read back wrong");

  a_ctrl_readback: assert property (
    (reg_rd && reg_addr == `CTRL_OFS)
      |=> (reg_rdata == {31'h0, $past(led_support_en)})
  ) else $error("LED support switch read back wrong");

  // status is a snapshot of the latch, so a read shows the straps of this reset
  a_status_read: assert property (
    (reg_rd && reg_addr == `STATUS_OFS)
      |=> (reg_rdata == {24'h0, $past(strap_valid), $past(strap.boost), $past(strap.gang), $past(strap.swap)})
  ) else $error("status read does not show the latched straps");

  // capture is a single edge per reset; a second one would reload the straps
  a_capture_once: assert property (
    (phase == led_strap_pkg::phase_run)
      |=> !capture
  ) else $error("second strap capture without reset");

  a_valid_after_capture: assert property (
    capture
      |=> (strap_valid && phase == led_strap_pkg::phase_run)
  ) else $error("strap latch not marked valid after capture");

  c_swap_taken: cover property (capture && strap_en.swap && primary_led_in != 4'h0);
  c_gang_taken: cover property (capture && strap_en.gang && port3_enhanced_led_in);
  c_boost_both: cover property (capture && strap_en.boost && port12_enhanced_led_in == 2'h3);
  c_sw_boost: cover property (phase == led_strap_pkg::phase_run && reg_wr && reg_addr == `BOOST_OFS);
  c_mixed_lit: cover property (phase == led_strap_pkg::phase_run && led_support_en && strap.boost == 2'h1);

endmodule : led_strap_sampler

//--- sim/strap_board_model.sv
// ----------------------------------------
// board side: strap pull resistors and LEDs
// ----------------------------------------
module strap_board_model (
  input wire logic [7:0] pull,
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin settles to its resistor, so the strap level is steady through reset
  assign pin = (oe & out) | (~oe & pull);
endmodule : strap_board_model

//--- sim/tb.sv
`include "led_strap_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and pins
  // ----------------------------------------
  // pin bits: 3:0 primary, 4 port3, 6:5 port2/1, 7 port4 (bits 6:0 match status layout)
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  led_strap_pkg::strap_en_type strap_en = 3'h7;
  logic [3:0] primary_led_req = 4'h0;
  logic [3:0] enhanced_led_req = 4'h0;
  logic [7:0] pull = 8'h00;
  wire logic [7:0] oe, out, pin;
  logic [3:0] port_pair_swap_strap;
  logic gang_power_mode;
  logic [1:0] phy_output_current_setting;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  led_strap_sampler i_led_strap_sampler (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_en(strap_en),
    .primary_led_req(primary_led_req), .enhanced_led_req(enhanced_led_req), .primary_led_in(pin[3:0]),
    .port_primary_led_out(out[3:0]), .primary_led_oe(oe[3:0]), .port4_enhanced_led_in(pin[7]),
    .port4_enhanced_led_out(out[7]), .port4_enhanced_led_oe(oe[7]), .port3_enhanced_led_in(pin[4]),
    .port3_enhanced_led_out(out[4]), .port3_enhanced_led_oe(oe[4]), .port12_enhanced_led_in(pin[6:5]),
    .port12_enhanced_led_out(out[6:5]), .port12_enhanced_led_oe(oe[6:5]),
    .port_pair_swap_strap(port_pair_swap_strap), .gang_power_mode(gang_power_mode),
    .phy_output_current_setting(phy_output_current_setting));
  strap_board_model i_strap_board_model (.pull(pull), .oe(oe), .out(out), .pin(pin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // bus tasks start and end just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset with given straps, then light the LEDs both ways round
  task automatic test_straps(input logic [7:0] p, input led_strap_pkg::strap_en_type e);
    logic [7:0] lat;
    logic [7:0] al;
    logic [31:0] d;
    lat = p & {1'b0, {2{e.boost}}, e.gang, {4{e.swap}}};
    al = {1'b1, e.boost ? p[6:5] : 2'h3, e.gang ? p[4] : 1'b1, e.swap ? p[3:0] : 4'hf};
    pull <= p;
    strap_en <= e;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("swap", {28'h0, port_pair_swap_strap}, {28'h0, lat[3:0]});
    check("gang", {31'h0, gang_power_mode}, {31'h0, lat[4]});
    check("boost", {30'h0, phy_output_current_setting}, {30'h0, lat[6:5]});
    check("oe_reset", {24'h0, oe}, 32'h0);
    @(posedge clk_sys);
    rd(`STATUS_OFS, d);
    check("status", d, {24'h0, 1'b1, lat[6:0]});
    wr(`CTRL_OFS, 32'h1);
    rd(`CTRL_OFS, d);
    check("ctrl_rd", d, 32'h1);
    for (int i = 0; i < 2; i++) begin
      primary_led_req <= i[0] ? 4'h6 : 4'h9;
      enhanced_led_req <= i[0] ? 4'ha : 4'h5;
      repeat (2) @(posedge clk_sys);
      #1;
      check("oe", {24'h0, oe}, 32'hff);
      d = {24'h0, {enhanced_led_req[3], enhanced_led_req[1:0], enhanced_led_req[2], primary_led_req} ^ al};
      check("led", {24'h0, out}, d);
      @(posedge clk_sys);
    end
    $display("straps test done %h", p);
  endtask : test_straps
  // straps stay put when the pulls move; register map corners
  task automatic test_hold;
    logic [31:0] d;
    pull <= 8'h00;
    wr(`CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk_sys);
    #1;
    check("oe_off", {24'h0, oe}, 32'h0);
    check("hold", {27'h0, gang_power_mode, port_pair_swap_strap}, 32'h1f);
    @(posedge clk_sys);
    wr(`BOOST_OFS, 32'h1);
    #1;
    check("boost_wr", {30'h0, phy_output_current_setting}, 32'h1);
    @(posedge clk_sys);
    wr(`STATUS_OFS, 32'h0);
    rd(`STATUS_OFS, d);
    check("status_ro", d, 32'hff);
    rd(8'h0c, d);
    check("unmapped", d, 32'h0);
    rd(`BOOST_OFS, d);
    check("boost_rd", d, 32'h1);
    $display("hold test done");
  endtask : test_hold
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    test_straps(8'h00, 3'h7);
    test_straps(8'h35, 3'h7);
    test_straps(8'h4a, 3'h7);
    test_straps(8'hff, 3'h0);
    test_straps(8'h7f, 3'h7);
    test_hold;
    test_done;
  end
  // the whole run needs about a hundred cycles; 2000 leaves room
  initial begin
    #20us;
    num_errors++;
    test_done;
  end
endmodule : tb
